// ### design/diom_top.sv
`timescale 1ns/1ns
`include "diom_map.svh"
// Notes on behaviour
// R1 - Ten channels; channel 4 is shutdown, channel 8 protection, neither reassignable.
// R2 - After reset every assignable channel is unassigned with nothing connected.
// R3 - Channels 1 to 3 accept only the thirteen control input functions.
// R4 - Channels 5 to 7 accept only the twelve status output functions.
// R5 - Channels 9 and 10 accept only clock and trigger in or out, or unassigned.
// R6 - Positive polarity means true is high; negative means true is low.
// R7 - Polarity writable except channel 4, readable for all ten channels.
// R8 - Polarity settings are kept in non-volatile storage across power cycles.
// R9 - Function readable for all ten channels, writable only for assignable ones.
// R10 - Digital input port reads as a six-bit value; only bits 0 to 2 (channels 1 to 3) can be set, giving 0 to 7.
// R11 - Digital output port is written as 0 to 63 and reads back.
// R12 - Polarity inverts both directions; unassigned outputs drive their false level.
module diom_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`DIOM_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`DIOM_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [`DIOM_NCH-1:0] pin_i,
  output logic [`DIOM_NCH-1:0] pin_o,
  output logic [`DIOM_NCH-1:0] pin_oe,
  input wire diom_pkg::diom_stat_s stat,
  output diom_pkg::diom_ctl_s ctl,
  input wire logic [`DIOM_NCH-1:0] nv_pol_load,
  output logic nv_store,
  output logic [`DIOM_NCH-1:0] nv_store_data
);

  ////////////////////////////////////////////////////////////////////////////////
  diom_pkg::diom_top_s st_ff;
  diom_pkg::diom_top_s nxt_st;
  diom_pkg::diom_req_s wr;
  diom_pkg::diom_ctl_s c;
  logic wr_err;
  logic rd_en;
  logic [`DIOM_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [`DIOM_NCH-1:0] pin_s;
  logic [`DIOM_NCH-1:0] lgc;
  logic [`DIOM_NCH-1:0] val;
  logic [`DIOM_NCH-1:0] np;
  logic [`DIOM_PORT_W-1:0] din;
  logic [3:0] widx;
  logic [3:0] ridx;
  logic [3:0] code;
  logic code_ok;

  diom_axil u_bus (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr(wr),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  diom_sync u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(pin_i),
    .q(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes, polarity restore and pin routing.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.nv_store = 1'b0;
    wr_err = 1'b0;
    widx = wr.addr[5:2];
    code = wr.data[3:0];
    code_ok = 1'b0;
    np = st_ff.pol;
    // R12 polarity applied inbound
    lgc = pin_s ^ st_ff.pol;
    // R8 restore saved polarity
    if (!st_ff.loaded) begin
      nxt_st.loaded = 1'b1;
      nxt_st.pol = nv_pol_load & `DIOM_POL_WMASK;
      nxt_st.pol[`DIOM_CH4_POL_BIT] = `DIOM_CH4_POL;
    end
    if (wr.en) begin
      if (wr.addr <= `DIOM_FUNC_LAST && wr.addr[1:0] == 2'h0) begin
        // R1 fixed channels refuse
        if (widx == `DIOM_CH4_IDX || widx == `DIOM_CH8_IDX) begin
          wr_err = 1'b1;
        end else if (wr.strb[0]) begin
          // R3 R4 R5 per-group legal codes
          if (widx < `DIOM_GRP_B_IDX) begin
            code_ok = code <= `DIOM_MAX_A;
          end else if (widx < `DIOM_GRP_C_IDX) begin
            code_ok = code <= `DIOM_MAX_B;
          end else begin
            code_ok = code <= `DIOM_MAX_C;
          end
          // R9 assignable channels only
          if (code_ok) begin
            nxt_st.func[widx] = code;
          end else begin
            wr_err = 1'b1;
          end
        end
      end else if (wr.addr == `DIOM_POL_ADDR) begin
        if (wr.strb[0]) begin
          np[7:0] = wr.data[7:0];
        end
        if (wr.strb[1]) begin
          np[9:8] = wr.data[9:8];
        end
        // R7 channel 4 polarity held
        nxt_st.pol = (np & `DIOM_POL_WMASK) | (st_ff.pol & ~`DIOM_POL_WMASK);
        // R8 push to storage
        nxt_st.nv_store = |wr.strb[1:0];
      end else if (wr.addr == `DIOM_DOUT_ADDR) begin
        // R11 output port write
        if (wr.strb[0]) begin
          nxt_st.dout = wr.data[5:0];
        end
      end else begin
        wr_err = 1'b1;
      end
    end

    // Inputs assigned to the same function are ORed together.
    c = '0;
    for (int i = 0; i < 3; i++) begin
      case (st_ff.func[i])
        diom_pkg::fa_output_on_control: c.output_on_control |= lgc[i];
        diom_pkg::fa_sequence_run_control: c.sequence_run_control |= lgc[i];
        diom_pkg::fa_protection_clear_request: c.protection_clear_request |= lgc[i];
        diom_pkg::fa_external_protection_input: c.external_protection_input |= lgc[i];
        diom_pkg::fa_wiring_select_single_phase: c.wiring_select_single_phase |= lgc[i];
        diom_pkg::fa_wiring_select_split_phase: c.wiring_select_split_phase |= lgc[i];
        diom_pkg::fa_wiring_select_three_phase: c.wiring_select_three_phase |= lgc[i];
        diom_pkg::fa_voltage_range_select: c.voltage_range_select |= lgc[i];
        diom_pkg::fa_preset_recall_one: c.preset_recall_one |= lgc[i];
        diom_pkg::fa_preset_recall_two: c.preset_recall_two |= lgc[i];
        diom_pkg::fa_output_block: c.output_block |= lgc[i];
        default: c.output_block |= 1'b0;
      endcase
    end
    // R1 channel 4 shutdown
    c.shutdown_request = lgc[3];
    for (int i = 8; i < 10; i++) begin
      case (st_ff.func[i])
        diom_pkg::fc_sync_clock_input: c.sync_clock_input |= lgc[i];
        diom_pkg::fc_sequence_trigger_input: c.sequence_trigger_input |= lgc[i];
        default: c.sync_clock_input |= 1'b0;
      endcase
    end
    nxt_st.ctl = c;

    // R12 unassigned drives false
    val = '0;
    nxt_st.pin_oe = `DIOM_OE_RST;
    for (int i = 4; i < 7; i++) begin
      case (st_ff.func[i])
        diom_pkg::fb_output_on_indicator: val[i] = stat.output_on_indicator;
        diom_pkg::fb_peak_current_limiting_flag: val[i] = stat.peak_current_limiting_flag;
        diom_pkg::fb_overload_flag: val[i] = stat.overload_flag;
        diom_pkg::fb_busy_indicator: val[i] = stat.busy_indicator;
        diom_pkg::fb_wiring_is_single_phase: val[i] = stat.wiring_is_single_phase;
        diom_pkg::fb_wiring_is_split_phase: val[i] = stat.wiring_is_split_phase;
        diom_pkg::fb_wiring_is_three_phase: val[i] = stat.wiring_is_three_phase;
        diom_pkg::fb_high_range_indicator: val[i] = stat.high_range_indicator;
        diom_pkg::fb_power_up_indicator: val[i] = stat.power_up_indicator;
        diom_pkg::fb_sequence_running_indicator: val[i] = stat.sequence_running_indicator;
        diom_pkg::fb_user_output_bit: val[i] = st_ff.dout[i-4];
        default: val[i] = 1'b0;
      endcase
    end
    // R1 channel 8 protection
    val[7] = stat.protection_active;
    for (int i = 8; i < 10; i++) begin
      case (st_ff.func[i])
        diom_pkg::fc_reference_clock_output: begin
          val[i] = stat.reference_clock_output;
          nxt_st.pin_oe[i] = 1'b1;
        end
        diom_pkg::fc_sequence_trigger_output: begin
          val[i] = stat.sequence_trigger_output;
          nxt_st.pin_oe[i] = 1'b1;
        end
        default: val[i] = 1'b0;
      endcase
    end
    // R6 polarity applied outbound
    nxt_st.pin_o = (val ^ st_ff.pol) & nxt_st.pin_oe;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    ridx = rd_addr[5:2];
    // R10 user input bits
    din = '0;
    for (int i = 0; i < 3; i++) begin
      din[i] = (st_ff.func[i] == diom_pkg::fa_user_input_bit) & lgc[i];
    end
    if (rd_addr <= `DIOM_FUNC_LAST && rd_addr[1:0] == 2'h0) begin
      // R9 fixed channels report
      if (ridx == `DIOM_CH4_IDX) begin
        rd_data[3:0] = `DIOM_FIXED_SHDN;
      end else if (ridx == `DIOM_CH8_IDX) begin
        rd_data[3:0] = `DIOM_FIXED_PROT;
      end else begin
        rd_data[3:0] = st_ff.func[ridx];
      end
    end else if (rd_addr == `DIOM_POL_ADDR) begin
      rd_data[9:0] = st_ff.pol;
    end else if (rd_addr == `DIOM_DIN_ADDR) begin
      rd_data[5:0] = din;
    end else if (rd_addr == `DIOM_DOUT_ADDR) begin
      rd_data[5:0] = st_ff.dout;
    end else if (rd_addr == `DIOM_PINS_ADDR) begin
      rd_data[9:0] = pin_s;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // R2 channels start unassigned
      st_ff <= '0;
      st_ff.pol <= `DIOM_POL_RST;
      st_ff.dout <= `DIOM_DOUT_RST;
      st_ff.pin_oe <= `DIOM_OE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_o = st_ff.pin_o;
  assign pin_oe = st_ff.pin_oe;
  assign ctl = st_ff.ctl;
  assign nv_store = st_ff.nv_store;
  assign nv_store_data = st_ff.pol;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_FIXED_DIRECTION: assert property ( // R1
    pin_oe[7] && !pin_oe[3]
  ) else $error("Fixed channel direction wrong.");

  AST_BOOT_UNASSIGNED: assert property ( // R2
    !st_ff.loaded |-> st_ff.func == '0 ##1 st_ff.func == '0
  ) else $error("Channels not unassigned after reset.");

  AST_GROUP_A_LEGAL: assert property ( // R3
    wr.en && wr.addr == `DIOM_FUNC_CH1 && wr.strb[0] && wr.data[3:0] > `DIOM_MAX_A
      |-> wr_err ##1 $stable(st_ff.func[0])
  ) else $error("Illegal channel 1 function taken.");

  AST_GROUP_B_LEGAL: assert property ( // R4
    wr.en && wr.addr == `DIOM_FUNC_CH5 && wr.strb[0] && wr.data[3:0] > `DIOM_MAX_B
      |-> wr_err ##1 $stable(st_ff.func[4])
  ) else $error("Illegal channel 5 function taken.");

  AST_GROUP_C_LEGAL: assert property ( // R5
    wr.en && wr.addr == `DIOM_FUNC_CH9 && wr.strb[0] && wr.data[3:0] > `DIOM_MAX_C
      |-> wr_err ##1 $stable(st_ff.func[8])
  ) else $error("Illegal channel 9 function taken.");

  AST_OUT_POLARITY: assert property ( // R6
    st_ff.func[4] == diom_pkg::fb_output_on_indicator
      |=> pin_o[4] == ($past(stat.output_on_indicator) ^ $past(st_ff.pol[4]))
  ) else $error("Status output level does not follow polarity.");

  AST_CH4_POL_FIXED: assert property ( // R7
    st_ff.pol[`DIOM_CH4_POL_BIT] == `DIOM_CH4_POL
  ) else $error("Channel 4 polarity changed.");

  AST_POL_SAVED: assert property ( // R8
    wr.en && wr.addr == `DIOM_POL_ADDR && wr.strb[1:0] == 2'h3
      |=> nv_store && nv_store_data == (10'($past(wr.data)) & `DIOM_POL_WMASK) ##1 !nv_store
  ) else $error("Polarity write not saved.");

  AST_FIXED_FUNC: assert property ( // R9
    wr.en && wr.addr == `DIOM_FUNC_CH4 |-> wr_err ##1 $stable(st_ff.func[3])
  ) else $error("Channel 4 function write accepted.");

  AST_DIN_RANGE: assert property ( // R10
    rd_en && rd_addr == `DIOM_DIN_ADDR |-> rd_data[31:6] == '0 && !rd_err
  ) else $error("Input port read out of range.");

  AST_DOUT_READBACK: assert property ( // R11
    wr.en && wr.addr == `DIOM_DOUT_ADDR && wr.strb[0]
      |=> st_ff.dout == 6'($past(wr.data))
  ) else $error("Output port value not kept.");

  AST_UNASSIGNED_FALSE: assert property ( // R12
    st_ff.func[5] == diom_pkg::fb_unassigned
      |=> pin_oe[5] && pin_o[5] == $past(st_ff.pol[5])
  ) else $error("Unassigned output not at false level.");

endmodule

// ### design/diom_map.svh
`ifndef DIOM_MAP_SVH
`define DIOM_MAP_SVH

`define DIOM_NCH 10
`define DIOM_FUNC_W 4
`define DIOM_ADDR_W 8
`define DIOM_PORT_W 6

`define DIOM_FUNC_BASE 8'h00
`define DIOM_FUNC_LAST 8'h24
`define DIOM_FUNC_CH1 8'h00
`define DIOM_FUNC_CH4 8'h0C
`define DIOM_FUNC_CH5 8'h10
`define DIOM_FUNC_CH6 8'h14
`define DIOM_FUNC_CH9 8'h20
`define DIOM_POL_ADDR 8'h40
`define DIOM_DIN_ADDR 8'h44
`define DIOM_DOUT_ADDR 8'h48
`define DIOM_PINS_ADDR 8'h4C

`define DIOM_CH4_IDX 4'h3
`define DIOM_CH8_IDX 4'h7
`define DIOM_GRP_B_IDX 4'h4
`define DIOM_GRP_C_IDX 4'h8
`define DIOM_CH4_POL_BIT 3

`define DIOM_MAX_A 4'hC
`define DIOM_MAX_B 4'hB
`define DIOM_MAX_C 4'h4
`define DIOM_FIXED_SHDN 4'hE
`define DIOM_FIXED_PROT 4'hF

`define DIOM_FUNC_RST 4'h0
`define DIOM_POL_RST 10'h000
`define DIOM_POL_WMASK 10'h3F7
`define DIOM_CH4_POL 1'b0
`define DIOM_OE_RST 10'h0F0
`define DIOM_DOUT_RST 6'h00

`define DIOM_RESP_OKAY 2'h0
`define DIOM_RESP_SLVERR 2'h2

`endif

// ### design/diom_pkg.sv
`include "diom_map.svh"
package diom_pkg;

  typedef enum logic [3:0] {
    fa_unassigned = 4'h0,
    fa_output_on_control,
    fa_sequence_run_control,
    fa_protection_clear_request,
    fa_external_protection_input,
    fa_wiring_select_single_phase,
    fa_wiring_select_split_phase,
    fa_wiring_select_three_phase,
    fa_voltage_range_select,
    fa_preset_recall_one,
    fa_preset_recall_two,
    fa_output_block,
    fa_user_input_bit
  } diom_fa_e;

  typedef enum logic [3:0] {
    fb_unassigned = 4'h0,
    fb_output_on_indicator,
    fb_peak_current_limiting_flag,
    fb_overload_flag,
    fb_busy_indicator,
    fb_wiring_is_single_phase,
    fb_wiring_is_split_phase,
    fb_wiring_is_three_phase,
    fb_high_range_indicator,
    fb_power_up_indicator,
    fb_sequence_running_indicator,
    fb_user_output_bit
  } diom_fb_e;

  typedef enum logic [3:0] {
    fc_unassigned = 4'h0,
    fc_sync_clock_input,
    fc_sequence_trigger_input,
    fc_reference_clock_output,
    fc_sequence_trigger_output
  } diom_fc_e;

  typedef struct packed {
    logic output_on_indicator;
    logic peak_current_limiting_flag;
    logic overload_flag;
    logic busy_indicator;
    logic wiring_is_single_phase;
    logic wiring_is_split_phase;
    logic wiring_is_three_phase;
    logic high_range_indicator;
    logic power_up_indicator;
    logic sequence_running_indicator;
    logic protection_active;
    logic reference_clock_output;
    logic sequence_trigger_output;
  } diom_stat_s;

  typedef struct packed {
    logic output_on_control;
    logic sequence_run_control;
    logic protection_clear_request;
    logic external_protection_input;
    logic wiring_select_single_phase;
    logic wiring_select_split_phase;
    logic wiring_select_three_phase;
    logic voltage_range_select;
    logic preset_recall_one;
    logic preset_recall_two;
    logic output_block;
    logic shutdown_request;
    logic sync_clock_input;
    logic sequence_trigger_input;
  } diom_ctl_s;

  typedef struct packed {
    logic en;
    logic [`DIOM_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } diom_req_s;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [`DIOM_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } diom_axs_s;

  typedef struct packed {
    logic [`DIOM_NCH-1:0] s1;
    logic [`DIOM_NCH-1:0] s2;
    logic [`DIOM_NCH-1:0] s3;
    logic [`DIOM_NCH-1:0] q;
  } diom_sync_s;

  typedef struct packed {
    logic [`DIOM_NCH-1:0][`DIOM_FUNC_W-1:0] func;
    logic [`DIOM_NCH-1:0] pol;
    logic [`DIOM_PORT_W-1:0] dout;
    logic [`DIOM_NCH-1:0] pin_o;
    logic [`DIOM_NCH-1:0] pin_oe;
    diom_ctl_s ctl;
    logic nv_store;
    logic loaded;
  } diom_top_s;

endpackage

// ### design/diom_sync.sv
`timescale 1ns/1ns
`include "diom_map.svh"
module diom_sync (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`DIOM_NCH-1:0] d,
  output logic [`DIOM_NCH-1:0] q
);

  diom_pkg::diom_sync_s s_ff;
  diom_pkg::diom_sync_s nxt_s;

  // A pin level is accepted only once the second and third stages agree.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = d;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    for (int i = 0; i < `DIOM_NCH; i++) begin
      if (s_ff.s2[i] == s_ff.s3[i]) begin
        nxt_s.q[i] = s_ff.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.q;

endmodule

// ### design/diom_axil.sv
`timescale 1ns/1ns
`include "diom_map.svh"
module diom_axil (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`DIOM_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`DIOM_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output diom_pkg::diom_req_s wr,
  input wire logic wr_err,
  output logic rd_en,
  output logic [`DIOM_ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  diom_pkg::diom_axs_s s_ff;
  diom_pkg::diom_axs_s nxt_s;

  // Address and data are caught in either order; the write fires once both are held.
  always_comb begin
    nxt_s = s_ff;
    awready = !s_ff.aw_got;
    wready = !s_ff.w_got;
    arready = !s_ff.rvalid;
    if (awvalid && !s_ff.aw_got) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.addr = awaddr;
    end
    if (wvalid && !s_ff.w_got) begin
      nxt_s.w_got = 1'b1;
      nxt_s.data = wdata;
      nxt_s.strb = wstrb;
    end
    wr.en = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    wr.addr = s_ff.addr;
    wr.data = s_ff.data;
    wr.strb = s_ff.strb;
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wr.en) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = wr_err ? `DIOM_RESP_SLVERR : `DIOM_RESP_OKAY;
    end
    rd_en = arvalid && !s_ff.rvalid;
    rd_addr = araddr;
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_en) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_data;
      nxt_s.rresp = rd_err ? `DIOM_RESP_SLVERR : `DIOM_RESP_OKAY;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;

endmodule

// ### bench/diom_far_model.sv
`timescale 1ns/1ns
`include "diom_map.svh"
module diom_far_model (
  input wire logic [`DIOM_NCH-1:0] pin_o,
  input wire logic [`DIOM_NCH-1:0] pin_oe,
  input wire logic [`DIOM_NCH-1:0] ext_lvl,
  output logic [`DIOM_NCH-1:0] pin_i
);
  // A wire shows the device drive where it is enabled and the equipment level elsewhere.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

// ### bench/test_digital_io_channel_mapper.sv
`timescale 1ns/1ns
`include "diom_map.svh"
module test_digital_io_channel_mapper;
  logic ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready, nv_store;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] pin_i, pin_o, pin_oe, nv_pol_load, nv_store_data, ext_lvl;
  diom_pkg::diom_stat_s stat;
  diom_pkg::diom_ctl_s ctl;
  int fails, total_checks, stores;
  localparam logic [1:0] rok = `DIOM_RESP_OKAY;
  localparam logic [1:0] rerr = `DIOM_RESP_SLVERR;

  diom_top dut (.ref_clk(ref_clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .stat(stat), .ctl(ctl),
    .nv_pol_load(nv_pol_load), .nv_store(nv_store), .nv_store_data(nv_store_data));
  diom_far_model far (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (nv_store === 1'b1) stores <= stores + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    if (bvalid !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    if (rvalid !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // power-up state
  task automatic t_reset();
    tick(2);
    chk({22'h0, pin_oe}, {22'h0, `DIOM_OE_RST});
    chk({22'h0, pin_o}, 32'h0);
    rd(`DIOM_POL_ADDR, 32'h2, rok);
    for (int c = 0; c < 10; c++) begin
      rd(8'(4 * c), (c == 3) ? 32'hE : (c == 7) ? 32'hF : 32'h0, rok);
    end
    rd(`DIOM_DOUT_ADDR, 32'h0, rok);
    rd(8'h80, 32'h0, rerr);
    wr(`DIOM_DIN_ADDR, 32'h1, rerr);
    $display("test reset done");
  endtask

  task automatic t_func();
    wr(`DIOM_FUNC_CH1, 32'hC, rok);
    wr(`DIOM_FUNC_CH1, 32'hD, rerr);
    wr(`DIOM_FUNC_CH5, 32'hB, rok);
    wr(`DIOM_FUNC_CH5, 32'hC, rerr);
    wr(`DIOM_FUNC_CH9, 32'h4, rok);
    wr(`DIOM_FUNC_CH9, 32'h5, rerr);
    wr(`DIOM_FUNC_CH4, 32'h0, rerr);
    wr(8'h1C, 32'h0, rerr);
    rd(`DIOM_FUNC_CH1, 32'hC, rok);
    rd(`DIOM_FUNC_CH5, 32'hB, rok);
    rd(`DIOM_FUNC_CH9, 32'h4, rok);
    rd(`DIOM_FUNC_CH4, 32'hE, rok);
    rd(8'h1C, 32'hF, rok);
    $display("test func done");
  endtask

  task automatic t_out();
    int s;
    diom_pkg::diom_stat_s sv;
    s = stores;
    sv = '0;
    sv.overload_flag = 1'b1;
    sv.protection_active = 1'b1;
    stat <= sv;
    wr(`DIOM_FUNC_CH6, {28'h0, diom_pkg::fb_overload_flag}, rok);
    wr(`DIOM_FUNC_CH9, {28'h0, diom_pkg::fc_reference_clock_output}, rok);
    wr(`DIOM_DOUT_ADDR, 32'h21, rok);
    tick(3);
    chk({29'h0, pin_o[6:4]}, 32'h3);
    chk({31'h0, pin_o[7]}, 32'h1);
    chk({31'h0, pin_oe[8]}, 32'h1);
    wr(`DIOM_POL_ADDR, 32'h70, rok);
    tick(3);
    chk({29'h0, pin_o[6:4]}, 32'h4);
    chk(stores, s + 1);
    chk({22'h0, nv_store_data}, 32'h70);
    rd(`DIOM_DOUT_ADDR, 32'h21, rok);
    $display("test out done");
  endtask

  task automatic t_pol();
    wr(`DIOM_POL_ADDR, 32'h3FF, rok);
    tick(3);
    rd(`DIOM_POL_ADDR, {22'h0, `DIOM_POL_WMASK}, rok);
    chk({22'h0, nv_store_data}, {22'h0, `DIOM_POL_WMASK});
    wr(`DIOM_FUNC_CH5, {28'h0, diom_pkg::fb_output_on_indicator}, rok);
    tick(3);
    chk({31'h0, pin_o[4]}, 32'h1);
    chk({31'h0, pin_o[7]}, 32'h0);
    $display("test pol done");
  endtask

  task automatic t_in();
    wr(`DIOM_POL_ADDR, 32'h0, rok);
    ext_lvl <= 10'h009;
    tick(6);
    rd(`DIOM_DIN_ADDR, 32'h1, rok);
    chk({31'h0, ctl.shutdown_request}, 32'h1);
    wr(`DIOM_POL_ADDR, 32'h1, rok);
    tick(6);
    rd(`DIOM_DIN_ADDR, 32'h0, rok);
    chk({31'h0, ctl.shutdown_request}, 32'h1);
    wr(8'h04, {28'h0, diom_pkg::fa_output_on_control}, rok);
    wr(8'h24, {28'h0, diom_pkg::fc_sync_clock_input}, rok);
    ext_lvl <= 10'h20B;
    tick(6);
    chk({31'h0, ctl.output_on_control}, 32'h1);
    chk({31'h0, ctl.sync_clock_input}, 32'h1);
    chk({31'h0, pin_oe[9]}, 32'h0);
    rd(`DIOM_PINS_ADDR, 32'h2AB, rok);
    $display("test in done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    stat = '0;
    nv_pol_load = 10'h00A;
    ext_lvl = 10'h000;
    fails = 0;
    total_checks = 0;
    stores = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_func();
    t_out();
    t_pol();
    t_in();
    report_and_stop();
  end
endmodule
